/* File: rtl/embedded_block_memory.sv */
// 9-Kbit block memory with input registers, output latches and fifo pointers
//
// Function
// - 9-Kbit array with input and output registers
// - single, true dual, pseudo dual or fifo
// - rewind returns fifo read pointer to start
// - user tracks packet boundaries for retransmit
// - per-port latches, sync or async clear
// - each port clear hits only its latch
// - chip-wide reset clears both latches
// - chip-wide reset always acts asynchronously
// - enables low one cycle around reset
// - clocks steady one fmax period if enabled; not enforced here, left to the fabric
// - reset release meets sync setup time
`timescale 1ns/100ps
`default_nettype none
module embedded_block_memory (
  input wire logic clk,
  input wire logic rst,
  ebm_if.device    bus
);
  typedef struct packed {
    logic        a_wr;
    logic        a_rd;
    logic [9:0]  a_addr;
    logic [17:0] a_wdata;
    logic        b_wr;
    logic        b_rd;
    logic [9:0]  b_addr;
    logic [17:0] b_wdata;
    logic [10:0] wr_ptr;
    logic [10:0] rd_ptr;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [17:0] mem [ebm_pkg::ROWS];

  logic [10:0] fill;
  logic [10:0] depth;
  logic        full;
  logic        empty;
  logic        fifo;
  logic        a_go;
  logic        b_go;
  logic [17:0] a_row;
  logic [17:0] b_row;
  logic [17:0] a_view;
  logic [17:0] b_view;

  // narrow mode packs two 9-bit words in one row; bit 0 picks the half
  function automatic logic [8:0] row_of(input logic [9:0] addr, input logic wide);
    row_of = wide ? addr[8:0] : addr[9:1];
  endfunction : row_of

  function automatic logic [17:0] view_of(input logic [17:0] row, input logic [9:0] addr,
                                          input logic wide);
    if (wide) begin
      view_of = row;
    end else begin
      view_of = {9'h000, addr[0] ? row[17:9] : row[8:0]};
    end
  endfunction : view_of

  assign fifo  = (bus.mode == ebm_pkg::MODE_FIFO);
  assign depth = bus.wide ? ebm_pkg::DEPTH_WIDE : ebm_pkg::DEPTH_NARROW;
  assign fill  = s_q.wr_ptr - s_q.rd_ptr;
  assign full  = (fill >= depth);
  assign empty = (fill == ebm_pkg::PTR_RESET);
  assign a_go  = bus.a_en;
  assign b_go  = bus.b_en;

  always_comb begin
    s_d         = s_q;
    s_d.a_wr    = 1'b0;
    s_d.a_rd    = 1'b0;
    s_d.b_wr    = 1'b0;
    s_d.b_rd    = 1'b0;
    s_d.a_wdata = bus.a_wdata;
    s_d.b_wdata = bus.b_wdata;
    s_d.a_addr  = bus.a_addr;
    s_d.b_addr  = bus.b_addr;
    case (bus.mode)
      ebm_pkg::MODE_SINGLE: begin
        s_d.a_wr = a_go & bus.a_we;
        s_d.a_rd = a_go & ~bus.a_we;
      end
      ebm_pkg::MODE_TRUE_DUAL: begin
        s_d.a_wr = a_go & bus.a_we;
        s_d.a_rd = a_go & ~bus.a_we;
        s_d.b_wr = b_go & bus.b_we;
        s_d.b_rd = b_go & ~bus.b_we;
      end
      ebm_pkg::MODE_PSEUDO_DUAL: begin
        s_d.a_wr = a_go & bus.a_we;
        s_d.b_rd = b_go;
      end
      ebm_pkg::MODE_FIFO: begin
        // writes beyond full and reads of empty are dropped
        s_d.a_wr   = a_go & bus.a_we & ~full;
        s_d.a_addr = s_q.wr_ptr[9:0];
        s_d.b_addr = s_q.rd_ptr[9:0];
        s_d.b_rd   = b_go & ~empty & ~bus.read_ptr_rewind;
        if (s_d.a_wr) begin
          s_d.wr_ptr = s_q.wr_ptr + 11'h001;
        end
        if (bus.read_ptr_rewind) begin
          s_d.rd_ptr = ebm_pkg::PTR_RESET;
        end else if (s_d.b_rd) begin
          s_d.rd_ptr = s_q.rd_ptr + 11'h001;
        end
      end
      default: begin
        s_d.a_wr = 1'b0;
      end
    endcase
    if (!fifo) begin
      s_d.wr_ptr = ebm_pkg::PTR_RESET;
      s_d.rd_ptr = ebm_pkg::PTR_RESET;
    end
    if (rst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  always_ff @(posedge clk) begin
    if (s_q.a_wr) begin
      if (bus.wide) begin
        mem[row_of(s_q.a_addr, 1'b1)] <= s_q.a_wdata;
      end else if (s_q.a_addr[0]) begin
        mem[row_of(s_q.a_addr, 1'b0)][17:9] <= s_q.a_wdata[8:0];
      end else begin
        mem[row_of(s_q.a_addr, 1'b0)][8:0] <= s_q.a_wdata[8:0];
      end
    end
    // port b lands last, so it wins a same-word collision
    if (s_q.b_wr) begin
      if (bus.wide) begin
        mem[row_of(s_q.b_addr, 1'b1)] <= s_q.b_wdata;
      end else if (s_q.b_addr[0]) begin
        mem[row_of(s_q.b_addr, 1'b0)][17:9] <= s_q.b_wdata[8:0];
      end else begin
        mem[row_of(s_q.b_addr, 1'b0)][8:0] <= s_q.b_wdata[8:0];
      end
    end
  end

  assign a_row  = mem[row_of(s_q.a_addr, bus.wide)];
  assign b_row  = mem[row_of(s_q.b_addr, bus.wide)];
  assign a_view = view_of(a_row, s_q.a_addr, bus.wide);
  assign b_view = view_of(b_row, s_q.b_addr, bus.wide);

  output_latch u_latch_a (
    .clk               (clk),
    .rst               (rst),
    .chip_wide_reset_n (bus.chip_wide_reset_n),
    .clear             (bus.port_a_latch_clear),
    .async_mode        (bus.async_clear_a),
    .load              (s_q.a_rd),
    .d                 (a_view),
    .q                 (bus.a_rdata)
  );

  output_latch u_latch_b (
    .clk               (clk),
    .rst               (rst),
    .chip_wide_reset_n (bus.chip_wide_reset_n),
    .clear             (bus.port_b_latch_clear),
    .async_mode        (bus.async_clear_b),
    .load              (s_q.b_rd),
    .d                 (b_view),
    .q                 (bus.b_rdata)
  );

  assign bus.fifo_full  = fifo & full;
  assign bus.fifo_empty = fifo & empty;
endmodule : embedded_block_memory
`default_nettype wire

/* File: rtl/ebm_pkg.sv */
// shared constants and types for the embedded block memory and its user end
package ebm_pkg;
  localparam int unsigned ARRAY_BITS   = 9216;
  localparam int unsigned WIDE_W       = 18;
  localparam int unsigned NARROW_W     = 9;
  localparam int unsigned ADDR_W       = 10;
  localparam int unsigned IDX_W        = 9;
  localparam int unsigned ROWS         = ARRAY_BITS / WIDE_W;
  localparam int unsigned PTR_W        = ADDR_W + 1;
  localparam logic [10:0] DEPTH_WIDE   = 11'h200;
  localparam logic [10:0] DEPTH_NARROW = 11'h400;
  localparam logic [10:0] PTR_RESET    = 11'h000;
  localparam logic [17:0] LATCH_RESET  = 18'h00000;
  // one quiet cycle of clock enables either side of a reset pulse
  localparam int unsigned QUIET_CYCLES = 1;
  localparam int unsigned HOLD_CYCLES  = 1;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_TRUE_DUAL,
    MODE_PSEUDO_DUAL,
    MODE_FIFO
  } mem_mode_t;
endpackage : ebm_pkg

/* File: rtl/ebm_if.sv */
// connection between the block memory and the fabric logic that drives it
`timescale 1ns/100ps
`default_nettype none
interface ebm_if (
  input wire logic clk
);
  ebm_pkg::mem_mode_t mode;
  logic        wide;
  logic        async_clear_a;
  logic        async_clear_b;
  logic        a_en;
  logic        a_we;
  logic [9:0]  a_addr;
  logic [17:0] a_wdata;
  logic [17:0] a_rdata;
  logic        b_en;
  logic        b_we;
  logic [9:0]  b_addr;
  logic [17:0] b_wdata;
  logic [17:0] b_rdata;
  logic        read_ptr_rewind;
  logic        port_a_latch_clear;
  logic        port_b_latch_clear;
  logic        chip_wide_reset_n;
  logic        fifo_full;
  logic        fifo_empty;

  modport device (
    input  clk, mode, wide, async_clear_a, async_clear_b,
    input  a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
    input  read_ptr_rewind, port_a_latch_clear, port_b_latch_clear, chip_wide_reset_n,
    output a_rdata, b_rdata, fifo_full, fifo_empty
  );
  modport user (
    input  clk, a_rdata, b_rdata, fifo_full, fifo_empty,
    output mode, wide, async_clear_a, async_clear_b,
    output a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
    output read_ptr_rewind, port_a_latch_clear, port_b_latch_clear, chip_wide_reset_n
  );
endinterface : ebm_if
`default_nettype wire

/* File: rtl/output_latch.sv */
// one port's data output register with selectable clear style
`timescale 1ns/100ps
`default_nettype none
module output_latch (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        chip_wide_reset_n,
  input  wire logic        clear,
  input  wire logic        async_mode,
  input  wire logic        load,
  input  wire logic [17:0] d,
  output logic      [17:0] q
);
  typedef struct packed {
    logic [17:0] data;
  } latch_t;

  latch_t s_q;
  latch_t s_d;
  logic   aclr;

  assign aclr = ~chip_wide_reset_n | (clear & async_mode);

  always_comb begin
    s_d = s_q;
    if (rst || (clear && !async_mode)) begin
      s_d.data = ebm_pkg::LATCH_RESET;
    end else if (load) begin
      s_d.data = d;
    end
  end

  always_ff @(posedge clk or posedge aclr) begin
    if (aclr) begin
      s_q.data <= ebm_pkg::LATCH_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.data;
endmodule : output_latch
`default_nettype wire

/* File: rtl/memory_user.sv */
// fabric-side driver of the block memory, sequencing enables around resets
`timescale 1ns/100ps
`default_nettype none
module memory_user (
  input  wire logic               clk,
  input  wire logic               rst,
  ebm_if.user                     bus,
  input  wire ebm_pkg::mem_mode_t cfg_mode,
  input  wire logic               cfg_wide,
  input  wire logic               cfg_async_a,
  input  wire logic               cfg_async_b,
  input  wire logic               a_req_en,
  input  wire logic               a_req_we,
  input  wire logic [9:0]         a_req_addr,
  input  wire logic [17:0]        a_req_wdata,
  output logic      [17:0]        a_rdata,
  input  wire logic               b_req_en,
  input  wire logic               b_req_we,
  input  wire logic [9:0]         b_req_addr,
  input  wire logic [17:0]        b_req_wdata,
  output logic      [17:0]        b_rdata,
  input  wire logic               rewind_req,
  input  wire logic               chip_reset_req,
  input  wire logic               clear_a_req,
  input  wire logic               clear_b_req,
  output logic                    fifo_full,
  output logic                    fifo_empty,
  output logic                    reset_busy
);
  typedef enum logic [1:0] {
    RS_IDLE,
    RS_QUIET_PRE,
    RS_HOLD,
    RS_QUIET_POST
  } rs_t;

  typedef struct packed {
    rs_t        st;
    logic [2:0] kind;
    logic [1:0] cnt;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   quiet;
  logic   hold;

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      RS_IDLE: begin
        if (chip_reset_req || clear_a_req || clear_b_req) begin
          s_d.kind = {clear_b_req, clear_a_req, chip_reset_req};
          s_d.cnt  = 2'(ebm_pkg::QUIET_CYCLES - 1);
          s_d.st   = RS_QUIET_PRE;
        end
      end
      RS_QUIET_PRE: begin
        if (s_q.cnt == 2'h0) begin
          s_d.cnt = 2'(ebm_pkg::HOLD_CYCLES - 1);
          s_d.st  = RS_HOLD;
        end else begin
          s_d.cnt = s_q.cnt - 2'h1;
        end
      end
      RS_HOLD: begin
        if (s_q.cnt == 2'h0) begin
          s_d.cnt = 2'(ebm_pkg::QUIET_CYCLES - 1);
          s_d.st  = RS_QUIET_POST;
        end else begin
          s_d.cnt = s_q.cnt - 2'h1;
        end
      end
      RS_QUIET_POST: begin
        if (s_q.cnt == 2'h0) begin
          s_d.st = RS_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 2'h1;
        end
      end
      default: begin
        s_d.st = RS_IDLE;
      end
    endcase
    if (rst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // enables follow the requests outside a reset sequence, so clock steadiness is left to the fabric
  assign quiet = (s_q.st != RS_IDLE);
  assign hold  = (s_q.st == RS_HOLD);

  assign bus.mode               = cfg_mode;
  assign bus.wide               = cfg_wide;
  assign bus.async_clear_a      = cfg_async_a;
  assign bus.async_clear_b      = cfg_async_b;
  assign bus.a_en               = a_req_en & ~quiet;
  assign bus.a_we               = a_req_we;
  assign bus.a_addr             = a_req_addr;
  assign bus.a_wdata            = a_req_wdata;
  assign bus.b_en               = b_req_en & ~quiet;
  assign bus.b_we               = b_req_we;
  assign bus.b_addr             = b_req_addr;
  assign bus.b_wdata            = b_req_wdata;
  assign bus.read_ptr_rewind    = rewind_req & ~quiet;
  assign bus.chip_wide_reset_n  = ~(hold & s_q.kind[0]);
  assign bus.port_a_latch_clear = hold & s_q.kind[1];
  assign bus.port_b_latch_clear = hold & s_q.kind[2];

  assign a_rdata    = bus.a_rdata;
  assign b_rdata    = bus.b_rdata;
  assign fifo_full  = bus.fifo_full;
  assign fifo_empty = bus.fifo_empty;
  assign reset_busy = quiet;
endmodule : memory_user
`default_nettype wire

/* File: sim/ebm_properties.sv */
// concurrent checks on the block memory interface
`timescale 1ns/100ps
`default_nettype none
module ebm_properties (
  input wire logic               clk,
  input wire logic               rst,
  input wire ebm_pkg::mem_mode_t mode,
  input wire logic               a_en,
  input wire logic               b_en,
  input wire logic               async_clear_a,
  input wire logic        [17:0] a_rdata,
  input wire logic        [17:0] b_rdata,
  input wire logic               read_ptr_rewind,
  input wire logic               port_a_latch_clear,
  input wire logic               port_b_latch_clear,
  input wire logic               chip_wide_reset_n,
  input wire logic               fifo_full,
  input wire logic               fifo_empty
);
  logic any_clear;
  assign any_clear = !chip_wide_reset_n || port_a_latch_clear || port_b_latch_clear;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence enables_off;
    !a_en && !b_en;
  endsequence
  // four idle cycles, so no read is still in flight
  sequence a_idle;
    (!a_en && !rst && chip_wide_reset_n && !port_a_latch_clear) [*4];
  endsequence
  pre_quiet_a: // quiet before
    assert property (any_clear |-> enables_off ##0 (!$past(a_en) && !$past(b_en)))
    else $error("enables active around a latch reset");
  post_quiet_a: // quiet after
    assert property ($rose(chip_wide_reset_n) || $fell(port_a_latch_clear) || $fell(port_b_latch_clear) |-> enables_off)
    else $error("enables active at reset release");
  chip_clear_a: // async clear
    assert property (!chip_wide_reset_n |-> a_rdata == ebm_pkg::LATCH_RESET && b_rdata == ebm_pkg::LATCH_RESET)
    else $error("chip-wide reset left a latch set");
  clear_a_only_a: // port a clear
    assert property (port_a_latch_clear && !port_b_latch_clear && chip_wide_reset_n
      |-> ##2 (a_rdata == ebm_pkg::LATCH_RESET && $stable(b_rdata)))
    else $error("port a clear wrong");
  clear_b_only_a: // port b clear
    assert property (port_b_latch_clear && !port_a_latch_clear && chip_wide_reset_n
      |-> ##2 (b_rdata == ebm_pkg::LATCH_RESET && $stable(a_rdata)))
    else $error("port b clear wrong");
  clear_late_a: // sync clear option
    assert property (port_a_latch_clear && !async_clear_a && chip_wide_reset_n && !$past(a_en, 2)
      |-> $stable(a_rdata))
    else $error("sync port a clear acted before its edge");
  clear_early_a: // async clear option
    assert property (port_a_latch_clear && async_clear_a |-> a_rdata == ebm_pkg::LATCH_RESET)
    else $error("async port a clear waited for an edge");
  latch_hold_a: // latch holds
    assert property (a_idle |-> $stable(a_rdata))
    else $error("port a latch moved without a read");
  rewind_keep_a: // rewind data
    assert property (read_ptr_rewind && mode == ebm_pkg::MODE_FIFO && !fifo_empty
      |=> !fifo_empty || mode != ebm_pkg::MODE_FIFO)
    else $error("rewind emptied the fifo");
  flags_idle_a: // flags outside fifo
    assert property (mode != ebm_pkg::MODE_FIFO |-> !fifo_full && !fifo_empty)
    else $error("fifo flag set outside fifo mode");
endmodule : ebm_properties
`default_nettype wire

/* File: sim/embedded_block_ram_reset_bench.sv */
// self-checking bench joining the block memory to its fabric-side driver
`timescale 1ns/100ps
`default_nettype none
module embedded_block_ram_reset_bench;
  logic               clk = 1'h0;
  logic               rst = 1'h1;
  ebm_pkg::mem_mode_t cfg_mode = ebm_pkg::MODE_TRUE_DUAL;
  logic               cfg_wide = 1'h1;
  logic               cfg_async_a = 1'h0;
  logic               cfg_async_b = 1'h0;
  logic               a_req_en = 1'h0;
  logic               a_req_we = 1'h0;
  logic [9:0]         a_req_addr = 10'h000;
  logic [17:0]        a_req_wdata = 18'h00000;
  logic               b_req_en = 1'h0;
  logic               b_req_we = 1'h0;
  logic [9:0]         b_req_addr = 10'h000;
  logic [17:0]        b_req_wdata = 18'h00000;
  logic [17:0]        a_rdata;
  logic [17:0]        b_rdata;
  logic               rewind_req = 1'h0;
  logic               chip_reset_req = 1'h0;
  logic               clear_a_req = 1'h0;
  logic               clear_b_req = 1'h0;
  logic               fifo_full;
  logic               fifo_empty;
  logic               reset_busy;
  int                 num_errors = 0;
  int                 samples_checked = 0;

  always #4 clk = ~clk;

  ebm_if bus_if (.clk(clk));
  embedded_block_memory embedded_block_memory_inst (.clk(clk), .rst(rst), .bus(bus_if));
  memory_user memory_user_inst (.clk, .rst, .bus(bus_if), .cfg_mode, .cfg_wide, .cfg_async_a, .cfg_async_b,
    .a_req_en, .a_req_we, .a_req_addr, .a_req_wdata, .a_rdata, .b_req_en, .b_req_we, .b_req_addr,
    .b_req_wdata, .b_rdata, .rewind_req, .chip_reset_req, .clear_a_req, .clear_b_req, .fifo_full,
    .fifo_empty, .reset_busy);
  ebm_properties ebm_properties_inst (.clk(clk), .rst(rst), .mode(bus_if.mode), .a_en(bus_if.a_en),
    .b_en(bus_if.b_en), .async_clear_a(bus_if.async_clear_a), .a_rdata(bus_if.a_rdata), .b_rdata(bus_if.b_rdata),
    .read_ptr_rewind(bus_if.read_ptr_rewind), .port_a_latch_clear(bus_if.port_a_latch_clear),
    .port_b_latch_clear(bus_if.port_b_latch_clear), .chip_wide_reset_n(bus_if.chip_wide_reset_n),
    .fifo_full(bus_if.fifo_full), .fifo_empty(bus_if.fifo_empty));

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // idle cycle after each op keeps every enable edge in its own time step
  task automatic op(logic ae, logic aw, logic [9:0] aa, logic [17:0] ad,
                    logic be, logic bw, logic [9:0] ba, logic [17:0] bd);
    {a_req_en, a_req_we, a_req_addr, a_req_wdata} = {ae, aw, aa, ad};
    {b_req_en, b_req_we, b_req_addr, b_req_wdata} = {be, bw, ba, bd};
    tick(1);
    a_req_en = 1'h0;
    b_req_en = 1'h0;
    tick(1);
  endtask : op

  // read data stands until the next read, so a late look is safe
  task automatic rd(logic port, logic [9:0] addr, logic [17:0] exp);
    op(!port, 1'h0, addr, 18'h00000, port, 1'h0, addr, 18'h00000);
    tick(3);
    check(port ? "b_rdata" : "a_rdata", port ? b_rdata : a_rdata, exp);
  endtask : rd

  task automatic pulse(logic [3:0] which);
    int n;
    int span;
    span = (which[2:0] != 3'h0) ? int'(2 * ebm_pkg::QUIET_CYCLES + ebm_pkg::HOLD_CYCLES) : 0;
    {rewind_req, chip_reset_req, clear_a_req, clear_b_req} = which;
    tick(1);
    {rewind_req, chip_reset_req, clear_a_req, clear_b_req} = 4'h0;
    n = 0;
    while (reset_busy !== 1'h0 && n < 20) begin
      tick(1);
      n++;
    end
    if (n == 20) begin
      num_errors++;
      results();
    end
    check("reset_busy_span", 18'(n), 18'(span)); // quiet span
  endtask : pulse

  initial begin
    tick(10);
    rst = 1'h0;
    for (int i = 0; i < 3; i++) begin
      cfg_mode = ebm_pkg::mem_mode_t'(i);
      op(1'h1, 1'h1, 10'(i), 18'h2A5A0 + 18'(i), 1'h0, 1'h0, 10'h000, 18'h00000);
      rd(i != 0, 10'(i), 18'h2A5A0 + 18'(i)); // mode readback
    end
    cfg_mode = ebm_pkg::MODE_TRUE_DUAL;
    op(1'h1, 1'h1, 10'h005, 18'h1ABCD, 1'h1, 1'h1, 10'h005, 18'h2F0F0);
    rd(1'h0, 10'h005, 18'h2F0F0); // collision winner
    cfg_wide = 1'h0;
    op(1'h1, 1'h1, 10'h3FF, 18'h001A5, 1'h0, 1'h0, 10'h000, 18'h00000);
    op(1'h1, 1'h1, 10'h3FE, 18'h0005A, 1'h0, 1'h0, 10'h000, 18'h00000);
    rd(1'h0, 10'h3FF, 18'h001A5); // narrow word
    cfg_wide = 1'h1;
    rd(1'h1, 10'h1FF, 18'h34A5A); // halves paired
    for (int i = 0; i < 2; i++) begin
      cfg_async_a = i[0];
      cfg_async_b = i[0];
      rd(1'h0, 10'h005, 18'h2F0F0); // contents kept
      rd(1'h1, 10'h1FF, 18'h34A5A); // contents kept
      pulse(4'h2);
      check("a_rdata", a_rdata, 18'h00000); // latch cleared
      check("b_rdata", b_rdata, 18'h34A5A); // other port kept
      rd(1'h0, 10'h005, 18'h2F0F0); // contents kept
      pulse(4'h1);
      check("b_rdata", b_rdata, 18'h00000); // latch cleared
      check("a_rdata", a_rdata, 18'h2F0F0); // other port kept
    end
    rd(1'h0, 10'h005, 18'h2F0F0); // contents kept
    rd(1'h1, 10'h1FF, 18'h34A5A); // contents kept
    pulse(4'h4);
    check("a_rdata", a_rdata, 18'h00000); // both cleared
    check("b_rdata", b_rdata, 18'h00000); // both cleared
    rd(1'h0, 10'h1FF, 18'h34A5A); // contents kept
    // mid-run fabric reset clears latches but never the array
    rst = 1'h1;
    tick(2);
    rst = 1'h0;
    check("a_rdata", a_rdata, 18'h00000); // reset clears latch only
    rd(1'h0, 10'h005, 18'h2F0F0); // contents kept
    // bench tracks words since pointer start
    cfg_mode = ebm_pkg::MODE_FIFO;
    tick(1);
    check("fifo_empty", 18'(fifo_empty), 18'h00001); // fifo starts empty
    for (int k = 0; k < 3; k++) begin
      op(1'h1, 1'h1, 10'h000, 18'h01000 + 18'(k), 1'h0, 1'h0, 10'h000, 18'h00000);
    end
    for (int k = 0; k < 3; k++) begin
      rd(1'h1, 10'h000, 18'h01000 + 18'(k)); // fifo order
    end
    check("fifo_empty", 18'(fifo_empty), 18'h00001); // drained fifo empty
    pulse(4'h8);
    tick(1);
    check("fifo_empty", 18'(fifo_empty), 18'h00000); // data held
    rd(1'h1, 10'h000, 18'h01000); // replay first
    rd(1'h1, 10'h000, 18'h01001); // replay second
    // 511 more words bring the count to the wide depth
    for (int k = 3; k < 514; k++) begin
      op(1'h1, 1'h1, 10'h000, 18'h01000 + 18'(k), 1'h0, 1'h0, 10'h000, 18'h00000);
    end
    check("fifo_full", 18'(fifo_full), 18'h00001); // full at depth
    op(1'h1, 1'h1, 10'h000, 18'h3FFFF, 1'h0, 1'h0, 10'h000, 18'h00000);
    rd(1'h1, 10'h000, 18'h01002); // write refused when full
    check("fifo_full", 18'(fifo_full), 18'h00000); // read frees a slot
    pulse(4'h8);
    rd(1'h1, 10'h000, 18'h01200); // rewind after wrap
    results();
  end
endmodule : embedded_block_ram_reset_bench
`default_nettype wire
